// ---- tbm_pkg.sv ----
// Purpose: Shared constants and carrier types for the test bus monitor multiplexer.
// Assumes: One system clock; all sources come from logic on that clock.
// Notes:   Selection codes and register offsets are named here once.
package tbm_pkg;

   // ----------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------
   localparam logic [7:0] TBM_OFS_SELECT   = 8'h70;
   localparam logic [7:0] TBM_OFS_READBACK = 8'h74;
   localparam logic [7:0] TBM_SELECT_RESET = 8'h00;
   localparam logic [7:0] TBM_ZERO_BYTE    = 8'h00;

   // ----------------------------------------------------------------
   // Selection codes
   // ----------------------------------------------------------------
   localparam logic [7:0] TBM_SEL_QUIET      = 8'h00;
   localparam logic [7:0] TBM_SEL_RSSI       = 8'h03;
   localparam logic [7:0] TBM_SEL_SQ_FIRST   = 8'h04;
   localparam logic [7:0] TBM_SEL_SQ_LO      = 8'h05;
   localparam logic [7:0] TBM_SEL_CORR_LO    = 8'h06;
   localparam logic [7:0] TBM_SEL_FREQ_LO    = 8'h07;
   localparam logic [7:0] TBM_SEL_PHASE_LO   = 8'h08;
   localparam logic [7:0] TBM_SEL_OSC_LO     = 8'h09;
   localparam logic [7:0] TBM_SEL_BITSYNC    = 8'h0A;
   localparam logic [7:0] TBM_SEL_PN_GEN     = 8'h0B;
   localparam logic [7:0] TBM_SEL_ADC_CAL    = 8'h0C;
   localparam logic [7:0] TBM_SEL_CORR_I     = 8'h0D;
   localparam logic [7:0] TBM_SEL_CORR_Q     = 8'h0E;
   localparam logic [7:0] TBM_SEL_CHIP_ERR   = 8'h0F;
   localparam logic [7:0] TBM_SEL_OSC_HI     = 8'h10;
   localparam logic [7:0] TBM_SEL_LAG_HI     = 8'h11;
   localparam logic [7:0] TBM_SEL_PHASE_ERR  = 8'h12;
   localparam logic [7:0] TBM_SEL_ROT_I      = 8'h13;
   localparam logic [7:0] TBM_SEL_ROT_Q      = 8'h14;
   localparam logic [7:0] TBM_SEL_ADC_IQ     = 8'h15;
   localparam logic [7:0] TBM_SEL_XOR_HI     = 8'h16;
   localparam logic [7:0] TBM_SEL_XOR_LO     = 8'h17;
   localparam logic [7:0] TBM_SEL_TIMING     = 8'h18;
   localparam logic [7:0] TBM_SEL_CAL_ACC_LO = 8'h19;
   localparam logic [7:0] TBM_SEL_CAL_ACC_HI = 8'h1A;
   localparam logic [7:0] TBM_SEL_FREQ_ACC   = 8'h1B;
   localparam logic [7:0] TBM_SEL_XOR_SLOW   = 8'h1C;
   localparam logic [7:0] TBM_SEL_SQ_HI      = 8'h1D;

   // ----------------------------------------------------------------
   // Internal quantities that may drive the test bus
   // ----------------------------------------------------------------
   typedef struct packed {
      logic        carrier_sense_early_enh;
      logic        carrier_sense_early;
      logic [5:0]  rssi;
      logic        rssi_adc_clock;
      logic [7:0]  signal_quality_first;
      logic [15:0] signal_quality_second;
      logic [15:0] signal_quality_third;
      logic        sq_third_for_diversity;
      logic        sq_valid_pulse;
      logic        sample_clock;
      logic        symbol_rate_clock;
      logic [7:0]  corr_mag_lo;
      logic [18:0] freq_reg_lo;
      logic [7:0]  phase_reg_lo;
      logic [15:0] osc_reg_lo;
      logic [4:0]  bitsync_mantissa;
      logic [2:0]  bitsync_exponent;
      logic        last_symbol;
      logic [8:0]  pn_gen_top;
      logic        adc_cal_full_scale;
      logic        energy_detect;
      logic        adc_cal_disable;
      logic [4:0]  adc_cal_code;
      logic        adc_cal_clock;
      logic [8:0]  corr_i_hi;
      logic [8:0]  corr_q_hi;
      logic [14:0] chip_err_accum;
      logic [19:0] osc_accum_hi;
      logic [18:0] lag_accum_hi;
      logic [6:0]  carrier_phase_err;
      logic [5:0]  inphase_rotation_error;
      logic [5:0]  quadrature_rotation_error;
      logic [2:0]  adc_i;
      logic [2:0]  adc_q;
      logic [8:0]  xor_hi;
      logic [8:0]  xor_lo;
      logic [7:0]  xor_slow;
      logic        jump_clock;
      logic        jump_count;
      logic [4:0]  master_timing_count;
      logic [17:0] cal_accum;
      logic [15:0] freq_accum_lo;
   } tbm_sources_s;

endpackage : tbm_pkg

// ---- tbm_mux.sv ----
// Purpose: Selects one internal quantity onto the eight test pins and the test strobe.
// Assumes: Configuration port logic on clk_sys issues single-cycle read and write strobes.
// Notes:   Pins are registered, so they lag the sources and the selection by one cycle.
`timescale 1ns/10ps

// Operation
// [RULE1] 03h: pin7 enhanced early sense, pin6 early sense, pins 5:0 signal strength.
// [RULE2] 03h: strobe carries strength converter clock; observer samples on its last rise.
// [RULE3] 04h: first quality measure on pins, strobe pulses when it is valid.
// [RULE4] 05h low byte, 1Dh high byte of second measure, or third for diversity.
// [RULE5] 06h: low-rate correlator magnitude, sample clock on strobe.
// [RULE6] 07h/08h/09h: frequency 18:11, phase 7:0, oscillator 15:8; symbol clock strobe.
// [RULE7] 0Ah: pins 7:3 bit sync mantissa, 2:0 exponent, strobe last symbol.
// [RULE8] 0Bh: top nine fault-test generator bits on pins plus strobe.
// [RULE9] 0Ch: full-scale flag, energy detect, cal disable, cal code; cal clock strobe.
// [RULE10] 0Dh/0Eh: high-rate I and Q correlator bits 8:1, sample clock strobe.
// [RULE11] 0Fh: chip error accumulator bits 14:7, strobe held low.
// [RULE12] 10h oscillator accum 19:12, 11h lag accum 18:11, sample clock strobe.
// [RULE13] 12h: seven-bit phase error with bit 6 repeated on pin 7.
// [RULE14] 13h/14h: six-bit rotation errors with bit 5 repeated on pins 7 and 6.
// [RULE15] 15h: pins 7:6 low, I converter on 5:3, Q converter on 2:0.
// [RULE16] 16h/17h: nine XOR test bits, high-rate or low-rate, on pins plus strobe.
// [RULE17] 18h: jump clock, jump count, symbol clock, master timing 4:0; sample strobe.
// [RULE18] 19h/1Ah: calibration accumulator bits 8:0 and 17:9 on pins plus strobe.
// [RULE19] 1Bh: low-rate frequency accumulator bits 15:7 on pins plus strobe.
// [RULE20] 1Ch: eight low-rate XOR test bits, symbol clock on strobe.
// [RULE21] 1Eh and 1Fh drive all pins and strobe low.
// [RULE22] Readback register is read-only and returns current test pin values.
// [RULE23] 00h is quiet: all pins and strobe low.
// [RULE24] Selection is eight-bit read/write; codes above 1Fh drive everything low.
module tbm_mux (
   // Clock and reset
   input  wire logic               clk_sys,
   input  wire logic               rst,
   // Configuration register port
   input  wire logic               cfg_wr_en,
   input  wire logic               cfg_rd_en,
   input  wire logic [7:0]         cfg_addr,
   input  wire logic [7:0]         cfg_wr_data,
   output logic      [7:0]         cfg_rd_data,
   output logic                    cfg_rd_valid,
   // Internal quantities
   input  wire tbm_pkg::tbm_sources_s src,
   // Test pins
   output logic      [7:0]         test_pins,
   output logic                    test_strobe
);

   // ----------------------------------------------------------------
   // Selection register
   // ----------------------------------------------------------------
   logic [7:0]  test_bus_select;
   logic [7:0]  next_pins;
   logic        next_strobe;
   logic [15:0] sq_sel;

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         test_bus_select <= tbm_pkg::TBM_SELECT_RESET;
      end else if (cfg_wr_en && cfg_addr == tbm_pkg::TBM_OFS_SELECT) begin
         test_bus_select <= cfg_wr_data;                          // see [RULE24]
      end
   end

   // ----------------------------------------------------------------
   // Source multiplexer
   // ----------------------------------------------------------------
   // The third measure stands in only while diversity uses it.
   assign sq_sel = src.sq_third_for_diversity ? src.signal_quality_third
                                              : src.signal_quality_second;   // see [RULE4]

   always_comb begin
      next_pins   = tbm_pkg::TBM_ZERO_BYTE;
      next_strobe = 1'h0;
      case (test_bus_select)
         tbm_pkg::TBM_SEL_RSSI: begin
            next_pins   = {src.carrier_sense_early_enh, src.carrier_sense_early, src.rssi};   // see [RULE1]
            next_strobe = src.rssi_adc_clock;                                                  // see [RULE2]
         end
         tbm_pkg::TBM_SEL_SQ_FIRST: begin
            next_pins   = src.signal_quality_first;                // see [RULE3]
            next_strobe = src.sq_valid_pulse;
         end
         tbm_pkg::TBM_SEL_SQ_LO: begin
            next_pins   = sq_sel[7:0];                             // see [RULE4]
            next_strobe = src.sq_valid_pulse;
         end
         tbm_pkg::TBM_SEL_SQ_HI: begin
            next_pins   = sq_sel[15:8];                            // see [RULE4]
            next_strobe = src.sq_valid_pulse;
         end
         tbm_pkg::TBM_SEL_CORR_LO: begin
            next_pins   = src.corr_mag_lo;                         // see [RULE5]
            next_strobe = src.sample_clock;
         end
         tbm_pkg::TBM_SEL_FREQ_LO: begin
            next_pins   = src.freq_reg_lo[18:11];                  // see [RULE6]
            next_strobe = src.symbol_rate_clock;
         end
         tbm_pkg::TBM_SEL_PHASE_LO: begin
            next_pins   = src.phase_reg_lo;                        // see [RULE6]
            next_strobe = src.symbol_rate_clock;
         end
         tbm_pkg::TBM_SEL_OSC_LO: begin
            next_pins   = src.osc_reg_lo[15:8];                    // see [RULE6]
            next_strobe = src.symbol_rate_clock;
         end
         tbm_pkg::TBM_SEL_BITSYNC: begin
            next_pins   = {src.bitsync_mantissa, src.bitsync_exponent};   // see [RULE7]
            next_strobe = src.last_symbol;
         end
         tbm_pkg::TBM_SEL_PN_GEN: begin
            {next_pins, next_strobe} = src.pn_gen_top;             // see [RULE8]
         end
         tbm_pkg::TBM_SEL_ADC_CAL: begin
            next_pins   = {src.adc_cal_full_scale, src.energy_detect,
                           src.adc_cal_disable, src.adc_cal_code};  // see [RULE9]
            next_strobe = src.adc_cal_clock;
         end
         tbm_pkg::TBM_SEL_CORR_I: begin
            next_pins   = src.corr_i_hi[8:1];                      // see [RULE10]
            next_strobe = src.sample_clock;
         end
         tbm_pkg::TBM_SEL_CORR_Q: begin
            next_pins   = src.corr_q_hi[8:1];                      // see [RULE10]
            next_strobe = src.sample_clock;
         end
         tbm_pkg::TBM_SEL_CHIP_ERR: begin
            next_pins   = src.chip_err_accum[14:7];                // see [RULE11]
            next_strobe = 1'h0;
         end
         tbm_pkg::TBM_SEL_OSC_HI: begin
            next_pins   = src.osc_accum_hi[19:12];                 // see [RULE12]
            next_strobe = src.sample_clock;
         end
         tbm_pkg::TBM_SEL_LAG_HI: begin
            next_pins   = src.lag_accum_hi[18:11];                 // see [RULE12]
            next_strobe = src.sample_clock;
         end
         tbm_pkg::TBM_SEL_PHASE_ERR: begin
            next_pins   = {src.carrier_phase_err[6], src.carrier_phase_err};   // see [RULE13]
            next_strobe = src.sample_clock;
         end
         tbm_pkg::TBM_SEL_ROT_I: begin
            next_pins   = {{2{src.inphase_rotation_error[5]}}, src.inphase_rotation_error};      // see [RULE14]
            next_strobe = src.sample_clock;
         end
         tbm_pkg::TBM_SEL_ROT_Q: begin
            next_pins   = {{2{src.quadrature_rotation_error[5]}}, src.quadrature_rotation_error}; // see [RULE14]
            next_strobe = src.sample_clock;
         end
         tbm_pkg::TBM_SEL_ADC_IQ: begin
            next_pins   = {2'h0, src.adc_i, src.adc_q};            // see [RULE15]
            next_strobe = src.sample_clock;
         end
         tbm_pkg::TBM_SEL_XOR_HI: begin
            {next_pins, next_strobe} = src.xor_hi;                 // see [RULE16]
         end
         tbm_pkg::TBM_SEL_XOR_LO: begin
            {next_pins, next_strobe} = src.xor_lo;                 // see [RULE16]
         end
         tbm_pkg::TBM_SEL_TIMING: begin
            next_pins   = {src.jump_clock, src.jump_count, src.symbol_rate_clock,
                           src.master_timing_count};                // see [RULE17]
            next_strobe = src.sample_clock;
         end
         tbm_pkg::TBM_SEL_CAL_ACC_LO: begin
            {next_pins, next_strobe} = src.cal_accum[8:0];         // see [RULE18]
         end
         tbm_pkg::TBM_SEL_CAL_ACC_HI: begin
            {next_pins, next_strobe} = src.cal_accum[17:9];        // see [RULE18]
         end
         tbm_pkg::TBM_SEL_FREQ_ACC: begin
            {next_pins, next_strobe} = src.freq_accum_lo[15:7];    // see [RULE19]
         end
         tbm_pkg::TBM_SEL_XOR_SLOW: begin
            next_pins   = src.xor_slow;                            // see [RULE20]
            next_strobe = src.symbol_rate_clock;
         end
         default: begin
            // Quiet, reserved and unassigned codes all hold the bus low.
            next_pins   = tbm_pkg::TBM_ZERO_BYTE;                  // see [RULE21] [RULE23] [RULE24]
            next_strobe = 1'h0;
         end
      endcase
   end

   // ----------------------------------------------------------------
   // Test pin registers
   // ----------------------------------------------------------------
   // Registering the pins removes mux glitches, at the cost of one cycle of skew
   // against the source strobes, which all pass through the same stage.
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         test_pins   <= tbm_pkg::TBM_ZERO_BYTE;
         test_strobe <= 1'h0;
      end else begin
         test_pins   <= next_pins;
         test_strobe <= next_strobe;                               // see [RULE2]
      end
   end

   // ----------------------------------------------------------------
   // Register read port
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         cfg_rd_data  <= tbm_pkg::TBM_ZERO_BYTE;
         cfg_rd_valid <= 1'h0;
      end else begin
         cfg_rd_valid <= cfg_rd_en;
         if (cfg_rd_en) begin
            case (cfg_addr)
               tbm_pkg::TBM_OFS_SELECT:   cfg_rd_data <= test_bus_select;
               tbm_pkg::TBM_OFS_READBACK: cfg_rd_data <= test_pins;           // see [RULE22]
               default:                   cfg_rd_data <= tbm_pkg::TBM_ZERO_BYTE;
            endcase
         end
      end
   end

endmodule : tbm_mux

// ---- tbm_ref_pkg.sv ----
// Purpose: Reference mapping of each selection onto the test bus, used by checker and bench.
// Assumes: Source struct as the design package declares it.
// Notes:   Result is {pins 7:0, strobe}; every selection not listed gives zero.
package tbm_ref_pkg;

   function automatic logic [8:0] tbm_expect(input logic [7:0] sel, input tbm_pkg::tbm_sources_s s);
      logic [15:0] sq;
      logic        sc;
      // The third measure takes over only while it serves antenna diversity.
      sq = s.sq_third_for_diversity ? s.signal_quality_third : s.signal_quality_second;
      sc = s.sample_clock;
      case (sel)
         8'h03: return {s.carrier_sense_early_enh, s.carrier_sense_early, s.rssi, s.rssi_adc_clock};
         8'h04: return {s.signal_quality_first, s.sq_valid_pulse};
         8'h05: return {sq[7:0], s.sq_valid_pulse};
         8'h1D: return {sq[15:8], s.sq_valid_pulse};
         8'h06: return {s.corr_mag_lo, sc};
         8'h07: return {s.freq_reg_lo[18:11], s.symbol_rate_clock};
         8'h08: return {s.phase_reg_lo, s.symbol_rate_clock};
         8'h09: return {s.osc_reg_lo[15:8], s.symbol_rate_clock};
         8'h0A: return {s.bitsync_mantissa, s.bitsync_exponent, s.last_symbol};
         8'h0B: return s.pn_gen_top;
         8'h0C: return {s.adc_cal_full_scale, s.energy_detect, s.adc_cal_disable, s.adc_cal_code,
                        s.adc_cal_clock};
         8'h0D: return {s.corr_i_hi[8:1], sc};
         8'h0E: return {s.corr_q_hi[8:1], sc};
         8'h0F: return {s.chip_err_accum[14:7], 1'h0};
         8'h10: return {s.osc_accum_hi[19:12], sc};
         8'h11: return {s.lag_accum_hi[18:11], sc};
         8'h12: return {s.carrier_phase_err[6], s.carrier_phase_err, sc};
         8'h13: return {{2{s.inphase_rotation_error[5]}}, s.inphase_rotation_error, sc};
         8'h14: return {{2{s.quadrature_rotation_error[5]}}, s.quadrature_rotation_error, sc};
         8'h15: return {2'h0, s.adc_i, s.adc_q, sc};
         8'h16: return s.xor_hi;
         8'h17: return s.xor_lo;
         8'h18: return {s.jump_clock, s.jump_count, s.symbol_rate_clock, s.master_timing_count, sc};
         8'h19: return s.cal_accum[8:0];
         8'h1A: return s.cal_accum[17:9];
         8'h1B: return s.freq_accum_lo[15:7];
         8'h1C: return {s.xor_slow, s.symbol_rate_clock};
         default: return 9'h000;
      endcase
   endfunction : tbm_expect

endpackage : tbm_ref_pkg

// ---- tbm_src_model.sv ----
// Purpose: Stands in for the modem datapaths that feed the test bus.
// Assumes: Quantities change on the falling edge, away from the sampling edge.
// Notes:   A shift register scrambles every field, so clocks and strobes toggle as well.
`timescale 1ns/10ps
module tbm_src_model (
   // Clock and reset
   input  wire logic             clk_sys,
   input  wire logic             rst,
   // Freezes all quantities while high
   input  wire logic             hold,
   // Quantities toward the multiplexer
   output tbm_pkg::tbm_sources_s src
);
   localparam int W = $bits(tbm_pkg::tbm_sources_s);
   logic [W-1:0] state;

   always @(negedge clk_sys or posedge rst) begin
      if (rst) begin
         state <= W'({10{32'hA5C3_1E97}});
      end else if (!hold) begin
         state <= {state[W-2:0], state[W-1] ^ state[W-5] ^ state[7]};
      end
   end

   assign src = state;
endmodule : tbm_src_model

// ---- tbm_mux_properties.sv ----
// Purpose: Concurrent checks on the test bus multiplexer ports.
// Assumes: Single clock domain; register writes take effect on the edge after the strobe.
// Notes:   A shadow of the selection register predicts the bus one cycle behind the sources.
`timescale 1ns/10ps
module tbm_mux_properties (
   // Clock and reset
   input  wire logic                  clk_sys,
   input  wire logic                  rst,
   // Configuration register port
   input  wire logic                  cfg_wr_en,
   input  wire logic                  cfg_rd_en,
   input  wire logic [7:0]            cfg_addr,
   input  wire logic [7:0]            cfg_wr_data,
   input  wire logic [7:0]            cfg_rd_data,
   input  wire logic                  cfg_rd_valid,
   // Sources and test pins
   input  wire tbm_pkg::tbm_sources_s src,
   input  wire logic [7:0]            test_pins,
   input  wire logic                  test_strobe
);
   logic      [7:0] sel_q;
   logic      [7:0] prev_sel;
   logic      [8:0] exp_bus;
   wire logic [8:0] bus = {test_pins, test_strobe};

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         sel_q <= tbm_pkg::TBM_SELECT_RESET;
      end else if (cfg_wr_en && cfg_addr == tbm_pkg::TBM_OFS_SELECT) begin
         sel_q <= cfg_wr_data;
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         prev_sel <= tbm_pkg::TBM_SELECT_RESET;
         exp_bus  <= 9'h000;
      end else begin
         prev_sel <= sel_q;
         exp_bus  <= tbm_ref_pkg::tbm_expect(sel_q, src);
      end
   end

   sequence s_rd_take(logic [7:0] a);
      cfg_rd_en && cfg_addr == a;
   endsequence

   a_quiet_zero: assert property (
      (prev_sel inside {8'h00, 8'h01, 8'h02, 8'h1E, 8'h1F} || prev_sel > 8'h1F) |-> bus == 9'h000)
      else $error("quiet selection drives the bus");
   a_rssi_map: assert property (prev_sel == 8'h03 |-> bus == exp_bus)
      else $error("strength selection wrong");
   a_quality_map: assert property (prev_sel inside {8'h04, 8'h05, 8'h1D} |-> bus == exp_bus)
      else $error("quality selection wrong");
   a_lowrate_map: assert property (prev_sel inside {[8'h06:8'h0A]} |-> bus == exp_bus)
      else $error("low-rate selection wrong");
   a_nine_bit: assert property (
      prev_sel inside {8'h0B, 8'h16, 8'h17, 8'h19, 8'h1A, 8'h1B} |-> bus == exp_bus)
      else $error("nine-bit selection wrong");
   a_hirate_map: assert property (
      prev_sel inside {[8'h0C:8'h15], 8'h18, 8'h1C} |-> bus == exp_bus)
      else $error("high-rate selection wrong");
   a_strobe_held: assert property (prev_sel == 8'h0F |-> !test_strobe && test_pins == exp_bus[8:1])
      else $error("chip error selection wrong");
   a_monitor_read: assert property (
      s_rd_take(8'h74) |=> cfg_rd_valid && cfg_rd_data == $past(test_pins))
      else $error("readback differs from pins");
   a_select_read: assert property (s_rd_take(8'h70) |=> cfg_rd_valid && cfg_rd_data == prev_sel)
      else $error("selection readback wrong");
   a_unmapped_read: assert property (
      cfg_rd_en && !(cfg_addr inside {8'h70, 8'h74}) |=> cfg_rd_valid && cfg_rd_data == 8'h00)
      else $error("unmapped read not zero");
endmodule : tbm_mux_properties

bind tbm_mux tbm_mux_properties i_props (.clk_sys(clk_sys), .rst(rst), .cfg_wr_en(cfg_wr_en), .cfg_rd_en(cfg_rd_en),
   .cfg_addr(cfg_addr), .cfg_wr_data(cfg_wr_data), .cfg_rd_data(cfg_rd_data), .cfg_rd_valid(cfg_rd_valid),
   .src(src), .test_pins(test_pins), .test_strobe(test_strobe));

// ---- test_bus_monitor_mux_test.sv ----
// Purpose: Self-checking bench for the test bus multiplexer.
// Assumes: Inputs change on the falling edge; the source model is frozen while comparing.
// Notes:   Every selection code is visited, plus 20h to 22h just above and FFh far above the defined range.
`timescale 1ns/10ps
module test_bus_monitor_mux_test;
   logic                  clk_sys, rst, cfg_wr_en, cfg_rd_en, cfg_rd_valid, test_strobe, hold;
   logic [7:0]            cfg_addr, cfg_wr_data, cfg_rd_data, test_pins, rd_val, sel;
   logic [8:0]            bus_exp;
   tbm_pkg::tbm_sources_s src;
   int                    n_fail, num_checks;

   tbm_src_model i_src (.clk_sys(clk_sys), .rst(rst), .hold(hold), .src(src));
   tbm_mux i_dut (.clk_sys(clk_sys), .rst(rst), .cfg_wr_en(cfg_wr_en), .cfg_rd_en(cfg_rd_en), .cfg_addr(cfg_addr),
      .cfg_wr_data(cfg_wr_data), .cfg_rd_data(cfg_rd_data), .cfg_rd_valid(cfg_rd_valid), .src(src),
      .test_pins(test_pins), .test_strobe(test_strobe));

   initial begin
      clk_sys = 1'h0;
      forever #25 clk_sys = ~clk_sys;
   end

   task automatic check(input logic [8:0] seen, input logic [8:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
      end
   endtask : check

   task automatic cfg_write(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk_sys);
      cfg_addr    = a;
      cfg_wr_data = d;
      cfg_wr_en   = 1'h1;
      @(negedge clk_sys);
      cfg_wr_en   = 1'h0;
   endtask : cfg_write

   // The answer stands for exactly one cycle after the strobe; a late or missing one is a mismatch.
   task automatic cfg_read(input logic [7:0] a, output logic [7:0] d);
      @(negedge clk_sys);
      cfg_addr  = a;
      cfg_rd_en = 1'h1;
      @(negedge clk_sys);
      cfg_rd_en = 1'h0;
      check({8'h00, cfg_rd_valid}, 9'h001);
      d = cfg_rd_data;
   endtask : cfg_read

   task automatic test_done();
      if (n_fail == 0 && num_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : test_done

   // A hang would otherwise leave the run open; the tests need well under 1000 cycles.
   initial begin
      #(5000 * 50);
      n_fail++;
      test_done();
   end

   initial begin
      rst         = 1'h1;
      cfg_wr_en   = 1'h0;
      cfg_rd_en   = 1'h0;
      cfg_addr    = 8'h00;
      cfg_wr_data = 8'h00;
      hold        = 1'h0;
      repeat (10) @(negedge clk_sys);
      rst = 1'h0;
      cfg_read(8'h70, rd_val);
      check({1'h0, rd_val}, 9'h000);
      cfg_read(8'h74, rd_val);
      check({1'h0, rd_val}, 9'h000);
      for (int s = 0; s < 36; s++) begin
         sel = (s == 35) ? 8'hFF : 8'(s);
         cfg_write(8'h70, sel);
         hold <= 1'h1;
         repeat (3) @(negedge clk_sys);
         bus_exp = tbm_ref_pkg::tbm_expect(sel, src);
         check({test_pins, test_strobe}, bus_exp);
         cfg_read(8'h74, rd_val);
         check({rd_val, 1'h0}, {bus_exp[8:1], 1'h0});
         cfg_read(8'h70, rd_val);
         check({1'h0, rd_val}, {1'h0, sel});
         hold <= 1'h0;
      end
      cfg_write(8'h74, 8'h5A);
      cfg_read(8'h70, rd_val);
      check({1'h0, rd_val}, 9'h0FF);
      cfg_read(8'h40, rd_val);
      check({1'h0, rd_val}, 9'h000);
      test_done();
   end
endmodule : test_bus_monitor_mux_test
